// file: ssh_soft_stop_handler.sv
`timescale 1ns/1ps
`include "ssh_consts.svh"

// How it works
// - a rising over-temperature indication starts the decelerate-and-halt sequence with no bus command.
// - the sequence first ramps the motor down to minimum velocity and then halts stepping, whatever the target.
// - once the motor is at rest the target position is loaded with the actual position.
// - that frame is our write address byte followed by command byte 8F, exactly two bytes.
module ssh_soft_stop_handler
    import ssh_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        over_temp_i,
    input  wire logic        rx_frame_start_i,
    input  wire logic        rx_byte_valid_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_frame_end_i,
    input  wire logic [3:0]  programmed_address_i,
    input  wire logic        hardwired_address_bit_i,
    input  wire logic [3:0]  velocity_i,
    input  wire logic [3:0]  min_velocity_i,
    input  wire logic        motor_at_rest_i,
    input  wire logic [15:0] actual_position_i,
    input  wire logic        motion_cmd_accepted_i,
    output logic             decel_to_vmin_o,
    output logic             halt_stepping_o,
    output logic             target_load_o,
    output logic [15:0]      target_position_o,
    output logic             soft_stop_active_o
);

    logic       ot_meta;
    logic       ot_sync;
    logic       ot_prev;
    logic       next_ot_meta;
    logic       next_ot_sync;
    logic       next_ot_prev;
    logic       cmd_hit;
    logic       trigger;
    ssh_state_t state;
    ssh_state_t next_state;
    logic       next_decel;
    logic       next_halt;
    logic       next_load;
    logic [15:0] next_target;

    // ----------------------------------------------------------------
    // frame recognition
    // ----------------------------------------------------------------
    ssh_frame_match u_frame (
        .ref_clk_i               (ref_clk_i),
        .reset_i                 (reset_i),
        .rx_frame_start_i        (rx_frame_start_i),
        .rx_byte_valid_i         (rx_byte_valid_i),
        .rx_byte_i               (rx_byte_i),
        .rx_frame_end_i          (rx_frame_end_i),
        .programmed_address_i    (programmed_address_i),
        .hardwired_address_bit_i (hardwired_address_bit_i),
        .cmd_hit_o               (cmd_hit)
    );

    // ----------------------------------------------------------------
    // over-temperature synchroniser and edge
    // ----------------------------------------------------------------
    // two flops before any logic reads the pin; the third only remembers the last synchronised level
    always_comb begin
        next_ot_meta = over_temp_i;
        next_ot_sync = ot_meta;
        next_ot_prev = ot_sync;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ot_meta <= 1'b0;
            ot_sync <= 1'b0;
            ot_prev <= 1'b0;
        end else begin
            ot_meta <= next_ot_meta;
            ot_sync <= next_ot_sync;
            ot_prev <= next_ot_prev;
        end
    end

    // edge, not level: a sensor stuck hot must not block motion forever
    assign trigger = (ot_sync && !ot_prev) || cmd_hit;

    // ----------------------------------------------------------------
    // stop sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_load   = 1'b0;
        next_target = target_position_o;
        case (state)
            SSH_IDLE: begin
                if (trigger) begin
                    next_state = SSH_DECEL;
                end
            end
            SSH_DECEL: begin
                // the ramp itself lives in the motion generator; we hold the request until it reports vmin
                if (velocity_i <= min_velocity_i) begin
                    next_state = SSH_HALT;
                end
            end
            SSH_HALT: begin
                // position taken in the first HALT cycle that sees rest, so later drift cannot creep into the target
                if (motor_at_rest_i) begin
                    next_state  = SSH_HOLD;
                    next_load   = 1'b1;
                    next_target = actual_position_i;
                end
            end
            SSH_HOLD: begin
                // a fresh stop request outranks the motion command
                if (trigger) begin
                    next_state = SSH_DECEL;
                end else if (motion_cmd_accepted_i) begin
                    next_state = SSH_IDLE;
                end
            end
            default: begin
                next_state = SSH_IDLE;
            end
        endcase
        next_decel = (next_state == SSH_DECEL);
        next_halt  = (next_state == SSH_HALT) || (next_state == SSH_HOLD);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state              <= SSH_IDLE;
            decel_to_vmin_o    <= 1'b0;
            halt_stepping_o    <= 1'b0;
            target_load_o      <= 1'b0;
            target_position_o  <= `SSH_POS_RESET;
            soft_stop_active_o <= 1'b0;
        end else begin
            state              <= next_state;
            decel_to_vmin_o    <= next_decel;
            halt_stepping_o    <= next_halt;
            target_load_o      <= next_load;
            target_position_o  <= next_target;
            soft_stop_active_o <= next_decel || next_halt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_ramp_done;
        decel_to_vmin_o && (velocity_i <= min_velocity_i);
    endsequence

    sequence s_at_rest;
        (state == SSH_HALT) && motor_at_rest_i;
    endsequence

    // a stop still on its way down: still ramping, or halted with rest not yet reached
    sequence s_stop_running;
        (state == SSH_DECEL) || (state == SSH_HALT);
    endsequence

    // a new request while the motor is already held at its stop position
    sequence s_hold_retrigger;
        (state == SSH_HOLD) && trigger;
    endsequence

    // the stop output dropped for a reason other than a reset
    sequence s_stop_dropped;
        $fell(soft_stop_active_o) && !$past(reset_i);
    endsequence

    a_heat_starts_stop: assert property ($rose(ot_sync) && state == SSH_IDLE |=> decel_to_vmin_o)
        else $error("over-temperature edge did not start deceleration");

    a_cmd_starts_stop: assert property (cmd_hit && state == SSH_IDLE |=> decel_to_vmin_o && soft_stop_active_o)
        else $error("stop frame did not start deceleration");

    a_ramp_holds: assert property (decel_to_vmin_o && velocity_i > min_velocity_i |=> decel_to_vmin_o)
        else $error("deceleration ended above minimum velocity");

    a_ramp_then_halt: assert property (s_ramp_done |=> halt_stepping_o && !decel_to_vmin_o)
        else $error("no halt after reaching minimum velocity");

    a_target_loaded: assert property (s_at_rest |=> target_load_o && target_position_o == $past(actual_position_i))
        else $error("target not loaded with actual position at rest");

    a_load_single: assert property (target_load_o |=> !target_load_o ##1 !target_load_o)
        else $error("target load repeated");

    a_hold_position: assert property (state == SSH_HOLD && !motion_cmd_accepted_i && !trigger |=> halt_stepping_o)
        else $error("halt released without a motion command");

    a_release_on_cmd: assert property (state == SSH_HOLD && motion_cmd_accepted_i && !trigger |=> !soft_stop_active_o)
        else $error("motion command did not release the halt");

    // edge and frame share one trigger path, so either must restart a held stop
    a_hold_restart: assert property (s_hold_retrigger |=> decel_to_vmin_o && !halt_stepping_o)
        else $error("stop request in hold did not restart deceleration");

    // once started, a stop never drops out before it reaches the hold state
    a_stop_persists: assert property (s_stop_running |=> soft_stop_active_o)
        else $error("stop sequence left before the motor was held");

    a_halt_after_ramp: assert property ($rose(halt_stepping_o) |-> $past(decel_to_vmin_o))
        else $error("halt raised without a preceding ramp");

    // a reset may clear the target without a load pulse, hence the guard on the cycle after it
    a_target_steady: assert property (!target_load_o && !$past(reset_i) |-> $stable(target_position_o))
        else $error("target position changed without a load");

    a_load_in_hold: assert property (target_load_o |-> halt_stepping_o && !decel_to_vmin_o)
        else $error("target loaded while the motor was not held");

    a_release_held: assert property (s_stop_dropped |-> $past(state) == SSH_HOLD)
        else $error("stop released before the hold state");

    a_idle_quiet: assert property (state == SSH_IDLE && !trigger |=> !soft_stop_active_o)
        else $error("stop started without a request");

endmodule

// file: ssh_consts.svh
`ifndef SSH_CONSTS_SVH
`define SSH_CONSTS_SVH

// ----------------------------------------------------------------
// command frame layout
// ----------------------------------------------------------------
`define SSH_ADDR_TOP        2'h3
`define SSH_WRITE_BIT       1'h0
`define SSH_CMD_DECEL_HALT  8'h8F

// ----------------------------------------------------------------
// byte counter positions within a frame
// ----------------------------------------------------------------
`define SSH_CNT_ADDR        2'h0
`define SSH_CNT_CMD         2'h1
`define SSH_CNT_FRAME       2'h2
`define SSH_CNT_MAX         2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSH_POS_RESET       16'h0000
`define SSH_BYTE_RESET      8'h00

`endif

// file: ssh_pkg.sv
package ssh_pkg;

    typedef enum logic [2:0] {
        SSH_IDLE,
        SSH_DECEL,
        SSH_HALT,
        SSH_HOLD
    } ssh_state_t;

endpackage

// file: ssh_frame_match.sv
`timescale 1ns/1ps
`include "ssh_consts.svh"

module ssh_frame_match
    import ssh_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       rx_frame_start_i,
    input  wire logic       rx_byte_valid_i,
    input  wire logic [7:0] rx_byte_i,
    input  wire logic       rx_frame_end_i,
    input  wire logic [3:0] programmed_address_i,
    input  wire logic       hardwired_address_bit_i,
    output logic            cmd_hit_o
);

    logic [1:0] count;
    logic       addr_ok;
    logic       cmd_ok;
    logic [1:0] next_count;
    logic       next_addr_ok;
    logic       next_cmd_ok;
    logic       next_cmd_hit;
    logic [1:0] base_count;
    logic [7:0] own_address;

    // ----------------------------------------------------------------
    // byte tracking
    // ----------------------------------------------------------------
    always_comb begin
        own_address  = {`SSH_ADDR_TOP, programmed_address_i, hardwired_address_bit_i, `SSH_WRITE_BIT};
        base_count   = rx_frame_start_i ? `SSH_CNT_ADDR : count;
        next_addr_ok = rx_frame_start_i ? 1'b0 : addr_ok;
        next_cmd_ok  = rx_frame_start_i ? 1'b0 : cmd_ok;
        next_count   = base_count;
        if (rx_byte_valid_i) begin
            if (base_count == `SSH_CNT_ADDR) begin
                next_addr_ok = (rx_byte_i == own_address);
            end
            if (base_count == `SSH_CNT_CMD) begin
                next_cmd_ok = (rx_byte_i == `SSH_CMD_DECEL_HALT);
            end
            // saturate so a longer frame never wraps back onto a match
            if (base_count != `SSH_CNT_MAX) begin
                next_count = 2'(base_count + 2'h1);
            end
        end
        // exactly two bytes: a third byte makes it another command
        next_cmd_hit = rx_frame_end_i && (count == `SSH_CNT_FRAME) && addr_ok && cmd_ok;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            count     <= `SSH_CNT_ADDR;
            addr_ok   <= 1'b0;
            cmd_ok    <= 1'b0;
            cmd_hit_o <= 1'b0;
        end else begin
            count     <= next_count;
            addr_ok   <= next_addr_ok;
            cmd_ok    <= next_cmd_ok;
            cmd_hit_o <= next_cmd_hit;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_hit_needs_end: assert property (cmd_hit_o |-> $past(rx_frame_end_i) && $past(count) == `SSH_CNT_FRAME)
        else $error("frame hit without a two byte frame end");
    a_hit_needs_match: assert property (cmd_hit_o |-> $past(addr_ok) && $past(cmd_ok))
        else $error("frame hit without address and command match");
    a_hit_is_pulse: assert property (cmd_hit_o |=> !cmd_hit_o)
        else $error("frame hit lasted more than one cycle");

endmodule

// file: ssh_bus_master_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// far-side bus master, already reduced to received-byte strobes
// ----------------------------------------------------------------
module ssh_bus_master_model (
    input  wire logic       ref_clk_i,
    output logic            frame_start_o,
    output logic            byte_valid_o,
    output logic [7:0]      byte_o,
    output logic            frame_end_o
);
    initial begin
        frame_start_o = 1'b0;
        byte_valid_o  = 1'b0;
        byte_o        = 8'h00;
        frame_end_o   = 1'b0;
    end

    // a frame may be sent at any time, also while a stop is running
    task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
        logic [7:0] seq [3];
        seq[0] = b0;
        seq[1] = b1;
        seq[2] = b2;
        @(negedge ref_clk_i);
        frame_start_o = 1'b1;
        @(negedge ref_clk_i);
        frame_start_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            byte_valid_o = 1'b1;
            byte_o       = seq[i];
            @(negedge ref_clk_i);
        end
        byte_valid_o = 1'b0;
        // released data must not look like the last byte
        byte_o       = ~byte_o;
        frame_end_o  = 1'b1;
        @(negedge ref_clk_i);
        frame_end_o  = 1'b0;
    endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        over_temp_i = 1'b0;
    logic        f_start, f_valid, f_end, at_rest = 1'b0, accepted = 1'b0;
    logic [7:0]  f_byte;
    logic [3:0]  prog_addr = 4'hA, vel = 4'h9, vmin = 4'h2;
    logic        hw_bit = 1'b1;
    logic [15:0] act_pos = 16'h0000, tgt_pos;
    logic        decel, halt, load, active;
    logic [7:0]  addr_byte;
    int          fail_count = 0;
    int          comparisons = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    ssh_bus_master_model u_master (.ref_clk_i(ref_clk_i), .frame_start_o(f_start), .byte_valid_o(f_valid),
                                   .byte_o(f_byte), .frame_end_o(f_end));

    ssh_soft_stop_handler u_dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .over_temp_i(over_temp_i),
        .rx_frame_start_i(f_start), .rx_byte_valid_i(f_valid), .rx_byte_i(f_byte), .rx_frame_end_i(f_end),
        .programmed_address_i(prog_addr), .hardwired_address_bit_i(hw_bit), .velocity_i(vel),
        .min_velocity_i(vmin), .motor_at_rest_i(at_rest), .actual_position_i(act_pos),
        .motion_cmd_accepted_i(accepted), .decel_to_vmin_o(decel), .halt_stepping_o(halt),
        .target_load_o(load), .target_position_o(tgt_pos), .soft_stop_active_o(active));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic summarize;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // walks a running stop down to rest and releases it with a motion command
    task automatic run_stop(input logic [15:0] pos);
        vel = 4'h9;
        cyc(3);
        chk("decel held", 16'h0001, {15'h0, decel});
        chk("halt early", 16'h0000, {15'h0, halt});
        vel = vmin;
        cyc(1);
        vel = 4'h0;
        chk("decel done", 16'h0000, {15'h0, decel});
        chk("halt on", 16'h0001, {15'h0, halt});
        accepted = 1'b1;
        cyc(1);
        accepted = 1'b0;
        act_pos  = pos;
        at_rest  = 1'b1;
        cyc(1);
        act_pos  = ~pos;
        chk("cmd ignored", 16'h0001, {15'h0, halt});
        chk("load pulse", 16'h0001, {15'h0, load});
        chk("target pos", pos, tgt_pos);
        cyc(1);
        chk("load once", 16'h0000, {15'h0, load});
        cyc(4);
        chk("held stop", 16'h0001, {15'h0, halt});
        chk("target kept", pos, tgt_pos);
        accepted = 1'b1;
        cyc(1);
        accepted = 1'b0;
        at_rest  = 1'b0;
        chk("released", 16'h0000, {15'h0, halt});
        chk("inactive", 16'h0000, {15'h0, active});
    endtask

    task automatic test_frame_stop;
        u_master.send_frame(addr_byte, 8'h8F, 8'h00, 2);
        chk("decel latency", 16'h0000, {15'h0, decel});
        cyc(1);
        chk("frame decel", 16'h0001, {15'h0, decel});
        chk("active", 16'h0001, {15'h0, active});
        run_stop(16'hB3C5);
    endtask

    task automatic test_bad_frames;
        u_master.send_frame(addr_byte ^ 8'h04, 8'h8F, 8'h00, 2);
        u_master.send_frame(addr_byte, 8'h87, 8'h00, 2);
        u_master.send_frame(addr_byte | 8'h01, 8'h8F, 8'h00, 2);
        u_master.send_frame(addr_byte, 8'h8F, 8'hFF, 3);
        cyc(4);
        chk("bad frames", 16'h0000, {15'h0, active});
    endtask

    task automatic test_over_temp;
        over_temp_i = 1'b1;
        cyc(2);
        chk("sync delay", 16'h0000, {15'h0, decel});
        cyc(1);
        chk("thermal decel", 16'h0001, {15'h0, decel});
        run_stop(16'h7E01);
        cyc(5);
        chk("no retrigger", 16'h0000, {15'h0, active});
        over_temp_i = 1'b0;
        cyc(4);
    endtask

    // a fresh request while held restarts the stop, even against a release in the same cycle
    task automatic test_hold_retrigger;
        vel     = 4'h0;
        at_rest = 1'b1;
        u_master.send_frame(addr_byte, 8'h8F, 8'h00, 2);
        cyc(3);
        chk("hold load", 16'h0001, {15'h0, load});
        chk("hold target", act_pos, tgt_pos);
        over_temp_i = 1'b1;
        cyc(2);
        accepted = 1'b1;
        cyc(1);
        accepted = 1'b0;
        chk("heat in hold", 16'h0001, {15'h0, decel});
        chk("halt dropped", 16'h0000, {15'h0, halt});
        cyc(2);
        chk("second halt", 16'h0001, {15'h0, halt});
        chk("second load", 16'h0001, {15'h0, load});
        accepted = 1'b1;
        cyc(1);
        accepted    = 1'b0;
        at_rest     = 1'b0;
        over_temp_i = 1'b0;
        chk("hold released", 16'h0000, {15'h0, active});
    endtask

    // a reset in the middle of a stop drops the request and the remembered target
    task automatic test_reset_mid;
        u_master.send_frame(addr_byte, 8'h8F, 8'h00, 2);
        cyc(2);
        chk("halt before reset", 16'h0001, {15'h0, halt});
        reset_i = 1'b1;
        cyc(2);
        reset_i = 1'b0;
        chk("reset drops stop", 16'h0000, {15'h0, active});
        cyc(1);
        chk("mid reset target", 16'h0000, tgt_pos);
        chk("reset stays idle", 16'h0000, {15'h0, active});
    endtask

    initial begin
        #(100 * 1500);
        fail_count++;
        summarize();
    end

    initial begin
        addr_byte = {2'b11, prog_addr, hw_bit, 1'b0};
        cyc(6);
        reset_i = 1'b0;
        cyc(1);
        chk("reset active", 16'h0000, {15'h0, active});
        chk("reset target", 16'h0000, tgt_pos);
        test_frame_stop();
        test_bad_frames();
        test_over_temp();
        test_hold_retrigger();
        test_reset_mid();
        test_frame_stop();
        summarize();
    end
endmodule
